// >>> pwm_ctrl_pkg.sv
/*
 * constants and types shared by the off-line regulator control core.
 * assumes a 125 MHz oscillator-derived clock on MCLK.
 */
package pwm_ctrl_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int SW_FREQ_HZ = 100000;
	localparam int CYCLE_CLKS = CLK_HZ / SW_FREQ_HZ;
	// maximum duty in percent, set by ramp symmetry
	localparam int MAX_DUTY_PCT = 67;
	localparam int MAX_ON_CLKS = CYCLE_CLKS * MAX_DUTY_PCT / 100;
	localparam int MIN_ON_NS = 700;
	localparam int MIN_ON_CLKS = (MIN_ON_NS * 125 + 999) / 1000;
	localparam int BLANK_NS = 180;
	localparam int BLANK_CLKS = (BLANK_NS * 125 + 999) / 1000;
	localparam int CNT_W = 11;
	localparam int DUTY_W = 8;
	localparam int RESTART_W = 3;
	localparam logic [RESTART_W-1:0] RESTART_LAST = 3'h7;
	localparam logic [DUTY_W-1:0] CTRL_MIN_LEVEL = 8'h20;
	localparam logic [RESTART_W-1:0] RESTART_RST = 3'h0;

	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_RUN = 2'b01,
		ST_RESTART = 2'b10,
		ST_HOLD = 2'b11
	} supply_st_t;
endpackage : pwm_ctrl_pkg

// >>> flag_sync.sv
/*
 * two-flop synchroniser for a group of comparator flags.
 * assumes flags are asynchronous to clk; output is registered.
 */
module flag_sync #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : flag_sync

// >>> pwm_autorestart_ctrl.sv
/*
 * control core: gate latch, modulator, current limit, supply window fsm,
 * auto-restart counter and overtemperature latch.
 * assumes comparator flags from the analog front end are asynchronous,
 * and CTRL_LEVEL is a static digitised error level (higher = less duty).
 */
// What this block does
// - upper threshold at start: source off, switching on
// - lower threshold: switch off, standby, source on
// - hysteretic: source on low, off high
// - count eight cycles before switching again
// - retry until regulation, then resume normal
// - lost feedback current enters hysteretic restart
// - set latch each cycle, 100 kHz
// - ramp crossing error level clears latch
// - on-time capped at maximum duty
// - minimum on-time every cycle not cut short by current limit, overtemperature or the lower threshold
// - maximum duty at or below minimum control level
// - current limit trip: off until next cycle
// - blank current limit after turn-on
// - overtemperature latches switch off
// - only power-up reset clears overtemperature latch
// - hysteretic regulation continues while latched off
// - charging source off while switching
module pwm_autorestart_ctrl #(
	parameter int CYCLE = pwm_ctrl_pkg::CYCLE_CLKS,
	parameter int MAX_ON = pwm_ctrl_pkg::MAX_ON_CLKS,
	parameter int MIN_ON = pwm_ctrl_pkg::MIN_ON_CLKS,
	parameter int BLANK = pwm_ctrl_pkg::BLANK_CLKS
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic VC_ABOVE_UPPER,
	input wire logic VC_BELOW_LOWER,
	input wire logic FB_PRESENT,
	input wire logic ILIM_TRIP,
	input wire logic OVER_TEMP,
	input wire logic [pwm_ctrl_pkg::DUTY_W-1:0] CTRL_LEVEL,
	output logic GATE_ON,
	output logic HV_SOURCE_ON,
	output logic STANDBY,
	output logic THERMAL_LATCHED,
	output logic [pwm_ctrl_pkg::RESTART_W-1:0] RESTART_COUNT,
	output logic CYCLE_START
);
	import pwm_ctrl_pkg::*;

	// ************************************************************
	// input synchronisation
	// ************************************************************
	logic [4:0] flags;
	logic vc_high;
	logic vc_low;
	logic fb_ok;
	logic ilim;
	logic hot;

	flag_sync #(.W(5)) u_sync (
		.clk(MCLK),
		.rst(RST),
		.d({VC_ABOVE_UPPER, VC_BELOW_LOWER, FB_PRESENT, ILIM_TRIP,
			OVER_TEMP}),
		.q(flags)
	);
	assign {vc_high, vc_low, fb_ok, ilim, hot} = flags;

	// ************************************************************
	// oscillator ramp
	// ************************************************************
	logic [CNT_W-1:0] ramp;
	logic [CNT_W-1:0] on_time;
	logic cycle_end;

	assign cycle_end = (ramp == CNT_W'(CYCLE - 1));

	always_ff @(posedge MCLK) begin
		if (RST) begin
			ramp <= '0;
			CYCLE_START <= 1'b0;
		end else begin
			ramp <= cycle_end ? '0 : ramp + 1'b1;
			CYCLE_START <= cycle_end;
		end
	end

	// ************************************************************
	// duty target from the error level
	// ************************************************************
	// linear map; below the minimum level the duty stays at maximum
	function automatic logic [CNT_W-1:0] duty_limit(
		input logic [DUTY_W-1:0] lvl
	);
		logic [CNT_W+DUTY_W-1:0] span;
		logic [CNT_W+DUTY_W-1:0] cut;
		span = '0;
		cut = '0;
		if (lvl <= CTRL_MIN_LEVEL) begin
			duty_limit = CNT_W'(MAX_ON);
		end else begin
			span = (CNT_W+DUTY_W)'(MAX_ON - MIN_ON);
			cut = span * (CNT_W+DUTY_W)'(lvl - CTRL_MIN_LEVEL)
				/ (CNT_W+DUTY_W)'(8'hff - CTRL_MIN_LEVEL);
			duty_limit = CNT_W'(MAX_ON) - CNT_W'(cut);
		end
	endfunction : duty_limit

	logic [CNT_W-1:0] target;
	assign target = duty_limit(CTRL_LEVEL);

	// ************************************************************
	// supply window state machine
	// ************************************************************
	supply_st_t state;
	logic enable_sw;

	assign enable_sw = (state == ST_RUN) && !THERMAL_LATCHED;

	// only RST clears the thermal latch
	always_ff @(posedge MCLK) begin
		if (RST)
			THERMAL_LATCHED <= 1'b0;
		else if (hot)
			THERMAL_LATCHED <= 1'b1;
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			state <= ST_START;
			RESTART_COUNT <= RESTART_RST;
		end else begin
			case (state)
			ST_START: begin
				if (vc_high)
					state <= ST_RUN;
			end
			ST_RUN: begin
				if (vc_low || (!fb_ok && vc_low))
					state <= ST_HOLD;
			end
			ST_HOLD: begin
				// discharged: recharge and count one cycle
				if (vc_high) begin
					if (RESTART_COUNT == RESTART_LAST &&
						!THERMAL_LATCHED) begin
						RESTART_COUNT <= RESTART_RST;
						state <= ST_RUN;
					end else begin
						RESTART_COUNT <= RESTART_COUNT + 1'b1;
						state <= ST_RESTART;
					end
				end
			end
			ST_RESTART: begin
				if (vc_low)
					state <= ST_HOLD;
			end
			default: state <= ST_START;
			endcase
		end
	end

	// no feedback current leaves vc falling to the low threshold,
	// which hands control to the hysteretic loop above
	always_ff @(posedge MCLK) begin
		if (RST) begin
			HV_SOURCE_ON <= 1'b1;
			STANDBY <= 1'b0;
		end else begin
			HV_SOURCE_ON <= (state == ST_START && !vc_high) ||
				(state == ST_HOLD && !vc_high) ||
				(state == ST_RUN && vc_low);
			STANDBY <= (state == ST_HOLD) || (state == ST_RESTART) ||
				(state == ST_RUN && vc_low);
		end
	end

	// ************************************************************
	// gate latch
	// ************************************************************
	logic ilim_seen;
	logic ilim_ok;

	assign ilim_ok = GATE_ON && (on_time >= CNT_W'(BLANK));

	always_ff @(posedge MCLK) begin
		if (RST)
			on_time <= '0;
		else if (cycle_end || !GATE_ON)
			on_time <= '0;
		else
			on_time <= on_time + 1'b1;
	end

	always_ff @(posedge MCLK) begin
		if (RST)
			ilim_seen <= 1'b0;
		else if (cycle_end)
			ilim_seen <= 1'b0;
		else if (ilim && ilim_ok)
			ilim_seen <= 1'b1;
	end

	// min on-time outranks duty but not current limit or faults
	always_ff @(posedge MCLK) begin
		if (RST) begin
			GATE_ON <= 1'b0;
		end else if (!enable_sw || hot || vc_low) begin
			GATE_ON <= 1'b0;
		end else if (cycle_end) begin
			GATE_ON <= 1'b1;
		end else if (GATE_ON) begin
			if (ilim && ilim_ok)
				GATE_ON <= 1'b0;
			else if (on_time + 1'b1 >= CNT_W'(MAX_ON))
				GATE_ON <= 1'b0;
			else if (on_time + 1'b1 >= target &&
				on_time + 1'b1 >= CNT_W'(MIN_ON))
				GATE_ON <= 1'b0;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	AST_MAX_DUTY: assert property (@(posedge MCLK) disable iff (RST)
		GATE_ON |-> on_time < CNT_W'(MAX_ON))
		else $error("on-time exceeded maximum duty");

	AST_MIN_ON: assert property (@(posedge MCLK) disable iff (RST)
		$fell(GATE_ON) && enable_sw && !hot && !vc_low && !ilim_seen
		|-> $past(on_time) + 1'b1 >=
		CNT_W'(MIN_ON))
		else $error("pulse shorter than minimum on-time");

	AST_ILIM_OFF: assert property (@(posedge MCLK) disable iff (RST)
		ilim_seen && !cycle_end |-> !GATE_ON)
		else $error("gate on after current limit");

	AST_THERM_HOLD: assert property (@(posedge MCLK) disable iff (RST)
		THERMAL_LATCHED |=> THERMAL_LATCHED)
		else $error("thermal latch cleared without reset");

	AST_THERM_OFF: assert property (@(posedge MCLK) disable iff (RST)
		THERMAL_LATCHED |=> !GATE_ON)
		else $error("gate on while thermally latched");

	AST_SRC_OFF: assert property (@(posedge MCLK) disable iff (RST)
		GATE_ON |-> !HV_SOURCE_ON)
		else $error("charging source on while switching");

	AST_SET: assert property (@(posedge MCLK) disable iff (RST)
		cycle_end && enable_sw && !hot && !vc_low |=> GATE_ON)
		else $error("latch not set at cycle start");

	AST_START_RUN: assert property (@(posedge MCLK) disable iff (RST)
		state == ST_START && vc_high |=> state == ST_RUN)
		else $error("no run after first upper threshold");

	AST_LOW_OFF: assert property (@(posedge MCLK) disable iff (RST)
		state == ST_RUN && vc_low |=> !GATE_ON && HV_SOURCE_ON)
		else $error("low threshold did not stop switching");

	AST_COUNT: assert property (@(posedge MCLK) disable iff (RST)
		state == ST_HOLD && vc_high && RESTART_COUNT != RESTART_LAST
		|=> state == ST_RESTART)
		else $error("restart before eight cycles");

	COV_RUN: cover property (@(posedge MCLK) $rose(GATE_ON));
	COV_ILIM: cover property (@(posedge MCLK) $rose(ilim_seen));
	COV_WRAP: cover property (@(posedge MCLK)
		state == ST_HOLD ##1 state == ST_RUN);
	COV_HOT: cover property (@(posedge MCLK) $rose(THERMAL_LATCHED));
endmodule : pwm_autorestart_ctrl

// >>> supply_model.sv
/*
 * supply capacitor and window comparators facing the control core.
 * assumes clk is the core clock; outputs change on its falling edge.
 */
module supply_model #(
	parameter int CYC = 100
) (
	input wire logic clk,
	input wire logic hv_on,
	input wire logic gate,
	input wire logic fb,
	output logic above,
	output logic below
);
	timeunit 1ns;
	timeprecision 1ps;
	int v = 0;
	int idle = 0;
	int slow = 0;
	// ****************************************
	// capacitor
	// ****************************************
	always @(negedge clk) begin
		idle <= gate ? 0 : (idle < 4 * CYC ? idle + 1 : idle);
		slow <= slow + 1;
		// source charges fast, drain is slow so startup reaches switching
		if (hv_on && v < 60) begin
			v <= v + 1;
		end else if (!hv_on && v > 40 && slow % 16 == 0 &&
			!(fb && idle < 2 * CYC)) begin
			v <= v - 1;
		end
		above <= v >= 57;
		below <= v <= 47;
	end
endmodule : supply_model

// >>> offline_pwm_autorestart_ctrl_tb.sv
/*
 * self-checking bench for the regulator control core.
 * assumes shrunk counts and the supply model as the far side.
 */
module offline_pwm_autorestart_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pwm_ctrl_pkg::*;
	localparam int CYC = 100;
	localparam int MAXON = 67;
	localparam int MINON = 8;
	localparam int BLK = 3;
	logic mclk = 0, rst = 1, fb = 1, ilim = 0, otemp = 0;
	logic above, below, gate, hv, stby, therm, cstart;
	logic [DUTY_W-1:0] level = 8'h00;
	logic [RESTART_W-1:0] count;
	int errors = 0;
	int checks_done = 0;
	pwm_autorestart_ctrl #(.CYCLE(CYC), .MAX_ON(MAXON), .MIN_ON(MINON),
		.BLANK(BLK)) uut (.MCLK(mclk), .RST(rst), .VC_ABOVE_UPPER(above),
		.VC_BELOW_LOWER(below), .FB_PRESENT(fb), .ILIM_TRIP(ilim),
		.OVER_TEMP(otemp), .CTRL_LEVEL(level), .GATE_ON(gate),
		.HV_SOURCE_ON(hv), .STANDBY(stby), .THERMAL_LATCHED(therm),
		.RESTART_COUNT(count), .CYCLE_START(cstart));
	supply_model #(.CYC(CYC)) far (.clk(mclk), .hv_on(hv), .gate(gate),
		.fb(fb), .above(above), .below(below));
	initial begin
		forever #4 mclk = ~mclk;
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// gate-high clocks and length of one full switching cycle
	task automatic on_time(output int hi, output int per);
		int k;
		k = 0;
		hi = 0;
		per = 0;
		while (cstart !== 1'b1 && k < 4 * CYC) begin
			@(negedge mclk);
			k++;
		end
		do begin
			hi += (gate === 1'b1);
			per++;
			@(negedge mclk);
		end while (cstart !== 1'b1 && per < 4 * CYC);
	endtask : on_time
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_start();
		int k, hi, per;
		k = 0;
		while (gate !== 1'b1 && k < 600) begin
			@(negedge mclk);
			k++;
		end
		check(hv, 1'b0);
		check(cstart, 1'b1);
		on_time(hi, per);
		on_time(hi, per);
		check(per, CYC);
		$display("startup done");
	endtask : t_start
	task automatic t_duty(input logic [7:0] lvl, input int exp);
		int hi, per;
		level = lvl;
		on_time(hi, per);
		on_time(hi, per);
		check(hi, exp);
		$display("duty %h done", lvl);
	endtask : t_duty
	task automatic t_ilim();
		int hi, per;
		level = 8'h00;
		ilim = 1;
		on_time(hi, per);
		on_time(hi, per);
		ilim = 0;
		check(hi, BLK + 1);
		$display("current limit done");
	endtask : t_ilim
	task automatic t_restart();
		int k, falls;
		logic last;
		k = 0;
		falls = 0;
		fb = 0;
		while (stby !== 1'b1 && k < 3000) begin
			@(negedge mclk);
			k++;
		end
		check({gate, hv, stby}, 3'h3);
		last = hv;
		while (gate !== 1'b1 && k < 9000) begin
			@(negedge mclk);
			falls += (last && !hv);
			last = hv;
			k++;
		end
		fb = 1;
		check(falls, 8);
		check(count, RESTART_RST);
		repeat (3 * CYC) @(negedge mclk);
		check({stby, hv}, 2'h0);
		$display("auto-restart done");
	endtask : t_restart
	task automatic t_thermal();
		int on_cnt, rises;
		logic last;
		on_cnt = 0;
		rises = 0;
		otemp = 1;
		repeat (5) @(negedge mclk);
		otemp = 0;
		repeat (3) @(negedge mclk);
		check(therm, 1'b1);
		last = hv;
		repeat (3000) begin
			@(negedge mclk);
			on_cnt += (gate !== 1'b0);
			rises += (!last && hv);
			last = hv;
		end
		check(on_cnt, 0);
		check(rises >= 2, 1'b1);
		rst = 1;
		repeat (3) @(negedge mclk);
		check({therm, hv, gate, count}, 6'h10);
		rst = 0;
		$display("thermal latch done");
	endtask : t_thermal
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (10) @(negedge mclk);
		check({gate, hv, stby, therm, count}, 7'h20);
		rst = 0;
		t_start();
		t_duty(8'h00, MAXON);
		t_duty(8'h20, MAXON);
		t_duty(8'hff, MINON);
		t_ilim();
		t_restart();
		t_thermal();
		t_start();
		print_verdict();
	end
	initial begin
		// whole run is well under 20000 clocks
		repeat (20000) @(posedge mclk);
		errors++;
		print_verdict();
	end
endmodule : offline_pwm_autorestart_ctrl_tb
